// [include/cop_pkg.sv]
// Constants, codes and carrier types of the clock output and synthesiser control block.
// Assumes a single core clock and a 32-bit classic Wishbone register port.
package cop_pkg;

    // ----------------------------------------------------------------
    // Register map (index times four is the byte address)
    // ----------------------------------------------------------------
    localparam logic [7:0] SYNTH_LOOP_CONTROL_IDX = 8'h3d;
    localparam logic [7:0] SYNTH_OUTPUT_DIVIDER_IDX = 8'h3e;
    localparam logic [7:0] CLOCK_OUT_STATUS_IDX = 8'h30;
    localparam logic [7:0] SYNTH_LOOP_CONTROL_ADR = 8'hf4;
    localparam logic [7:0] SYNTH_OUTPUT_DIVIDER_ADR = 8'hf8;
    localparam logic [7:0] CLOCK_OUT_STATUS_ADR = 8'hc0;

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int SEL_LSB = 4;
    localparam int PIN_EN_BIT = 3;
    localparam int POWER_DOWN_BIT = 2;
    localparam int FB_LSB = 0;
    localparam logic [7:0] LOOP_CONTROL_RESET = 8'h00;
    localparam logic [7:0] OUTPUT_DIVIDER_RESET = 8'h08;
    localparam logic [7:0] OUTPUT_DIVIDER_MIN = 8'h08;

    // ----------------------------------------------------------------
    // Feedback ratios
    // ----------------------------------------------------------------
    localparam logic [4:0] FB_RATIO_A = 5'h17;
    localparam logic [4:0] FB_RATIO_B = 5'h1b;
    localparam logic [4:0] FB_RATIO_C = 5'h1c;

    // ----------------------------------------------------------------
    // Clock rates
    // ----------------------------------------------------------------
    localparam int CORE_CLK_HZ = 50000000;
    localparam int INPUT_REF_KHZ = 27120;

    typedef enum logic [3:0] {
        COP_SEL_GPIO = 4'h0,
        COP_SEL_SYNTH = 4'h1,
        COP_SEL_LOW = 4'h2,
        COP_SEL_HIGH = 4'h3,
        COP_SEL_DIV1 = 4'h4,
        COP_SEL_DIV2 = 4'h5,
        COP_SEL_DIV4 = 4'h6,
        COP_SEL_DIV8 = 4'h7,
        COP_SEL_TMR0 = 4'h8,
        COP_SEL_TMR1 = 4'h9,
        COP_SEL_TMR2 = 4'ha,
        COP_SEL_TMR3 = 4'hb
    } cop_sel_e;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } cop_wb_req_s;

endpackage

// [src/cop_top.sv]
// Clock output source selector and synthesiser control registers.
// Assumes timer overflow pulses and pin I/O values come from logic on core_clk,
// and the synthesiser output arrives as an asynchronous level from the analog macro.
//
// Notes on behaviour
// - Bits 7..4 of the loop control register pick the pin source: 0h plain I/O, 1h synthesiser, Ch..Fh reserved.
// - Code 2h holds the clock pin low and code 3h holds it high.
// - Codes 4h..7h drive the pin with the reference clock divided by 1, 2, 4 and 8.
// - Codes 8h..Bh toggle the pin on each overflow of timer 0, 1, 2 or 3.
// - Bit 3 enables the chosen clock onto the pin, and when clear no clock is driven.
// - Bits 1..0 pick the loop feedback ratio 23, 27, 28, or 23 again for code 11.
// - The output divider register sets the division for 8..254, and values 0..7 must not be used.
// - Synthesiser output is the reference times the feedback ratio, halved, then over the output divider.
//
// Design decision made here: register access over Wishbone.
`timescale 1ns/10ps
module cop_top
    import cop_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire cop_wb_req_s wb_req,
    output logic wb_ack,
    output logic [31:0] wb_dat_rd,
    input wire logic [3:0] timer_overflow,
    input wire logic gpio_out_value,
    input wire logic gpio_out_enable,
    input wire logic synth_clk_async,
    output logic clock_output_pin,
    output logic clock_output_pin_oe,
    output logic synth_power_down,
    output logic [4:0] loop_feedback_ratio,
    output logic [7:0] loop_output_divide
);

    // ----------------------------------------------------------------
    // Registers and bus slave
    // ----------------------------------------------------------------
    logic [7:0] synth_loop_control;
    logic [7:0] synth_output_divider;
    logic bus_req;
    logic bus_wr;
    logic [31:0] next_rd;
    logic [3:0] clock_out_source_select;
    logic clock_out_pin_enable;
    logic [1:0] loop_feedback_divide;
    logic synth_running;
    logic div_clamped;

    assign bus_req = wb_req.cyc && wb_req.stb;
    // Write lands on the edge where ack is seen, as the classic master expects
    assign bus_wr = bus_req && wb_req.we && wb_ack && wb_req.sel[0];

    assign clock_out_source_select = synth_loop_control[SEL_LSB +: 4];
    assign clock_out_pin_enable = synth_loop_control[PIN_EN_BIT];
    assign loop_feedback_divide = synth_loop_control[FB_LSB +: 2];
    assign div_clamped = synth_output_divider < OUTPUT_DIVIDER_MIN;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wb_ack <= 1'b0;
        end else begin
            wb_ack <= bus_req && !wb_ack;
        end
    end

    always_comb begin
        next_rd = 32'h0000_0000;
        case (wb_req.adr)
            SYNTH_LOOP_CONTROL_ADR: next_rd[7:0] = synth_loop_control;
            SYNTH_OUTPUT_DIVIDER_ADR: next_rd[7:0] = synth_output_divider;
            CLOCK_OUT_STATUS_ADR: next_rd[3:0] = {div_clamped, synth_running, clock_output_pin_oe, clock_output_pin};
            default: next_rd = 32'h0000_0000;
        endcase
    end

    // Unmapped addresses are acknowledged and read as zero
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wb_dat_rd <= 32'h0000_0000;
        end else if (bus_req && !wb_ack) begin
            wb_dat_rd <= next_rd;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            synth_loop_control <= LOOP_CONTROL_RESET;
        end else if (bus_wr && wb_req.adr == SYNTH_LOOP_CONTROL_ADR) begin
            synth_loop_control <= wb_req.dat[7:0];
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            synth_output_divider <= OUTPUT_DIVIDER_RESET;
        end else if (bus_wr && wb_req.adr == SYNTH_OUTPUT_DIVIDER_ADR) begin
            synth_output_divider <= wb_req.dat[7:0];
        end
    end

    // ----------------------------------------------------------------
    // Synthesiser controls
    // ----------------------------------------------------------------
    logic [4:0] next_ratio;

    always_comb begin
        case (loop_feedback_divide)
            2'b01: next_ratio = FB_RATIO_B;
            2'b10: next_ratio = FB_RATIO_C;
            default: next_ratio = FB_RATIO_A;
        endcase
    end

    // ratio and divider handed to the analog loop
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            loop_feedback_ratio <= FB_RATIO_A;
            loop_output_divide <= OUTPUT_DIVIDER_RESET;
        end else begin
            loop_feedback_ratio <= next_ratio;
            // reserved divider values held at the smallest legal one
            loop_output_divide <= div_clamped ? OUTPUT_DIVIDER_MIN : synth_output_divider;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            synth_power_down <= 1'b0;
            synth_running <= 1'b0;
        end else begin
            synth_power_down <= synth_loop_control[POWER_DOWN_BIT];
            synth_running <= !synth_loop_control[POWER_DOWN_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Clock sources
    // ----------------------------------------------------------------
    logic synth_meta;
    logic synth_sync;
    logic [3:0] div_cnt;
    logic tmr_tgl;
    logic tmr_hit;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            synth_meta <= 1'b0;
            synth_sync <= 1'b0;
        end else begin
            synth_meta <= synth_clk_async;
            synth_sync <= synth_meta;
        end
    end

    // free divider, bit n has half period of 2^n core cycles
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            div_cnt <= 4'h0;
        end else begin
            div_cnt <= div_cnt + 4'h1;
        end
    end

    assign tmr_hit = clock_out_source_select[3:2] == 2'b10 && timer_overflow[clock_out_source_select[1:0]];

    // toggle on the selected timer overflow
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            tmr_tgl <= 1'b0;
        end else if (tmr_hit) begin
            tmr_tgl <= !tmr_tgl;
        end
    end

    // ----------------------------------------------------------------
    // Pin selector
    // ----------------------------------------------------------------
    logic next_pin;
    logic next_oe;

    always_comb begin
        next_pin = 1'b0;
        next_oe = clock_out_pin_enable;
        case (clock_out_source_select)
            // plain I/O ignores the clock enable
            COP_SEL_GPIO: begin
                next_pin = gpio_out_value;
                next_oe = gpio_out_enable;
            end
            // stopped synthesiser gives a steady low
            COP_SEL_SYNTH: next_pin = synth_sync && !synth_loop_control[POWER_DOWN_BIT];
            COP_SEL_LOW: next_pin = 1'b0;
            COP_SEL_HIGH: next_pin = 1'b1;
            COP_SEL_DIV1, COP_SEL_DIV2, COP_SEL_DIV4, COP_SEL_DIV8: begin
                next_pin = div_cnt[clock_out_source_select[1:0]];
            end
            COP_SEL_TMR0, COP_SEL_TMR1, COP_SEL_TMR2, COP_SEL_TMR3: next_pin = tmr_tgl;
            default: begin
                next_pin = 1'b0;
                next_oe = 1'b0;
            end
        endcase
        if (clock_out_source_select != COP_SEL_GPIO && !clock_out_pin_enable) begin
            next_pin = 1'b0;
            next_oe = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            clock_output_pin <= 1'b0;
            clock_output_pin_oe <= 1'b0;
        end else begin
            clock_output_pin <= next_pin;
            clock_output_pin_oe <= next_oe;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_gpio_pass;
        @(posedge core_clk) disable iff (!arst_n)
        clock_out_source_select == COP_SEL_GPIO |=>
            clock_output_pin == $past(gpio_out_value) && clock_output_pin_oe == $past(gpio_out_enable);
    endproperty
    a_gpio_pass: assert property (p_gpio_pass) else $error("pin does not follow plain I/O");

    property p_reserved_off;
        @(posedge core_clk) disable iff (!arst_n)
        clock_out_source_select >= 4'hc |=> !clock_output_pin_oe && !clock_output_pin;
    endproperty
    a_reserved_off: assert property (p_reserved_off) else $error("reserved code drives pin");

    property p_const_levels;
        @(posedge core_clk) disable iff (!arst_n)
        clock_out_pin_enable && clock_out_source_select inside {COP_SEL_LOW, COP_SEL_HIGH} |=>
            clock_output_pin_oe && clock_output_pin == $past(clock_out_source_select[0]);
    endproperty
    a_const_levels: assert property (p_const_levels) else $error("constant level wrong");

    property p_div8_period;
        @(posedge core_clk) disable iff (!arst_n)
        (clock_out_pin_enable && clock_out_source_select == COP_SEL_DIV8)[*2] ##1
            (clock_out_pin_enable && clock_out_source_select == COP_SEL_DIV8 && $rose(clock_output_pin)) ##1
            (clock_out_source_select == COP_SEL_DIV8 && clock_out_pin_enable)[*7] |=> !clock_output_pin;
    endproperty
    a_div8_period: assert property (p_div8_period) else $error("divide by 8 half period wrong");

    property p_div1_toggle;
        @(posedge core_clk) disable iff (!arst_n)
        (clock_out_pin_enable && clock_out_source_select == COP_SEL_DIV1)[*2] |=>
            clock_output_pin != $past(clock_output_pin);
    endproperty
    a_div1_toggle: assert property (p_div1_toggle) else $error("divide by 1 does not toggle");

    property p_timer_toggle;
        @(posedge core_clk) disable iff (!arst_n)
        (clock_out_pin_enable && clock_out_source_select == COP_SEL_TMR2 && timer_overflow[2]) ##1
            (clock_out_pin_enable && clock_out_source_select == COP_SEL_TMR2) |=>
            clock_output_pin != $past(clock_output_pin);
    endproperty
    a_timer_toggle: assert property (p_timer_toggle) else $error("timer overflow did not toggle pin");

    property p_disabled;
        @(posedge core_clk) disable iff (!arst_n)
        clock_out_source_select != COP_SEL_GPIO && !clock_out_pin_enable |=> !clock_output_pin_oe;
    endproperty
    a_disabled: assert property (p_disabled) else $error("pin driven while clock disabled");

    property p_fb_ratio;
        @(posedge core_clk) disable iff (!arst_n)
        1'b1 |=> loop_feedback_ratio == ($past(loop_feedback_divide) == 2'b01 ? 5'h1b :
            $past(loop_feedback_divide) == 2'b10 ? 5'h1c : 5'h17);
    endproperty
    a_fb_ratio: assert property (p_fb_ratio) else $error("feedback ratio decode wrong");

    property p_div_legal;
        @(posedge core_clk) disable iff (!arst_n)
        1'b1 |=> loop_output_divide >= 8'h08 &&
            (loop_output_divide == $past(synth_output_divider) || $past(synth_output_divider) < 8'h08);
    endproperty
    a_div_legal: assert property (p_div_legal) else $error("output divider handed out wrong");

    property p_div_write;
        @(posedge core_clk) disable iff (!arst_n)
        bus_wr && wb_req.adr == SYNTH_OUTPUT_DIVIDER_ADR && wb_req.dat[7:0] >= 8'h08 |=>
            ##1 loop_output_divide == $past(wb_req.dat[7:0], 2);
    endproperty
    a_div_write: assert property (p_div_write) else $error("divider write not passed to loop");

    property p_power_down;
        @(posedge core_clk) disable iff (!arst_n)
        synth_loop_control[POWER_DOWN_BIT] && clock_out_source_select == COP_SEL_SYNTH |=>
            synth_power_down && !synth_running && !clock_output_pin;
    endproperty
    a_power_down: assert property (p_power_down) else $error("synthesiser output not stopped");

    property p_ack_pulse;
        @(posedge core_clk) disable iff (!arst_n)
        bus_req && !wb_ack |=> wb_ack ##1 !wb_ack;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("bus ack not a single cycle");

    c_synth_route: cover property (@(posedge core_clk) disable iff (!arst_n)
        clock_output_pin_oe && clock_out_source_select == COP_SEL_SYNTH && $rose(clock_output_pin));
    c_timer_route: cover property (@(posedge core_clk) disable iff (!arst_n)
        tmr_hit && clock_out_pin_enable);
    c_div_clamp: cover property (@(posedge core_clk) disable iff (!arst_n) div_clamped);
    c_unmapped: cover property (@(posedge core_clk) disable iff (!arst_n)
        bus_req && wb_ack && wb_req.adr == 8'h00);

endmodule

// [dv/cop_pin_watch.sv]
// Receiving-end model of the clock output pin: counts level changes while driven.
// Assumes it samples on the core clock, which is at least as fast as any pin source.
`timescale 1ns/10ps
module cop_pin_watch (
    input wire logic core_clk,
    input wire logic clr,
    input wire logic pin,
    input wire logic pin_oe,
    output int n_edges
);
    logic prev;

    // An undriven pin carries no clock, so its changes are not counted
    always_ff @(posedge core_clk) begin
        prev <= pin;
        if (clr) begin
            n_edges <= 0;
        end else if (pin_oe === 1'b1 && pin !== prev) begin
            n_edges <= n_edges + 1;
        end
    end
endmodule

// [dv/cop_top_bench.sv]
// Self-checking bench for the clock output selector and synthesiser control registers.
// Assumes the register port answers one cycle after a request and the pin watcher model.
`timescale 1ns/10ps
module cop_top_bench;
    import cop_pkg::*;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    cop_wb_req_s wb_req = '0;
    logic wb_ack;
    logic [31:0] wb_dat_rd;
    logic [3:0] timer_overflow = 4'h0;
    logic gpio_out_value = 1'b0;
    logic gpio_out_enable = 1'b0;
    logic synth_clk_async = 1'b0;
    logic clock_output_pin;
    logic clock_output_pin_oe;
    logic synth_power_down;
    logic [4:0] loop_feedback_ratio;
    logic [7:0] loop_output_divide;
    logic clr = 1'b0;
    logic [1:0] sy_cnt = 2'h0;
    logic [31:0] q;
    logic [4:0] fb_exp [4] = '{5'h17, 5'h1b, 5'h1c, 5'h17};
    int n_edges;
    int n;
    int mismatches = 0;
    int n_tests = 0;

    always #10 core_clk = ~core_clk;

    // Synthesiser stand-in: slow square wave that halts while powered down
    always @(posedge core_clk) begin
        if (synth_power_down !== 1'b1) begin
            sy_cnt <= (sy_cnt == 2'h2) ? 2'h0 : sy_cnt + 2'h1;
            if (sy_cnt == 2'h2) begin
                synth_clk_async <= ~synth_clk_async;
            end
        end
    end

    cop_top i_cop_top (.core_clk(core_clk), .arst_n(arst_n), .wb_req(wb_req), .wb_ack(wb_ack),
        .wb_dat_rd(wb_dat_rd), .timer_overflow(timer_overflow), .gpio_out_value(gpio_out_value),
        .gpio_out_enable(gpio_out_enable), .synth_clk_async(synth_clk_async),
        .clock_output_pin(clock_output_pin), .clock_output_pin_oe(clock_output_pin_oe),
        .synth_power_down(synth_power_down), .loop_feedback_ratio(loop_feedback_ratio),
        .loop_output_divide(loop_output_divide));

    cop_pin_watch i_cop_pin_watch (.core_clk(core_clk), .clr(clr), .pin(clock_output_pin),
        .pin_oe(clock_output_pin_oe), .n_edges(n_edges));

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic finish_test;
        if (mismatches == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Waits as long as the slave needs; only the watchdog ends a hang
    task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] dat);
        @(posedge core_clk);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'h1, dat: {24'h0, dat}};
        do begin
            @(posedge core_clk);
        end while (wb_ack !== 1'b1);
        q = wb_dat_rd;
        wb_req <= '0;
        @(posedge core_clk);
        check(32'(wb_ack), 32'h0, "ack held too long");
    endtask

    task automatic rd(input logic [7:0] adr, input logic [31:0] exp, input string what);
        bus(1'b0, adr, 8'h00);
        check(q, exp, what);
    endtask

    // Settle time covers the synchroniser path on the synthesiser source
    task automatic ctl(input logic [7:0] v);
        bus(1'b1, SYNTH_LOOP_CONTROL_ADR, v);
        repeat (6) @(posedge core_clk);
    endtask

    // Counts pin changes over 64 core cycles, pulsing the given timers six times
    task automatic meas(input logic [3:0] pulse);
        @(posedge core_clk);
        clr <= 1'b1;
        @(posedge core_clk);
        clr <= 1'b0;
        for (int i = 0; i < 64; i++) begin
            @(posedge core_clk);
            timer_overflow <= (i % 10 == 5) ? pulse : 4'h0;
        end
        #1;
        n = n_edges;
    endtask

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        repeat (10) @(posedge core_clk);
        arst_n <= 1'b1;
        rd(SYNTH_LOOP_CONTROL_ADR, 32'h0, "control after reset");
        rd(SYNTH_OUTPUT_DIVIDER_ADR, 32'h8, "divider after reset");
        rd(8'h00, 32'h0, "unmapped read");
        bus(1'b1, 8'h00, 8'hff);
        rd(SYNTH_LOOP_CONTROL_ADR, 32'h0, "unmapped write ignored");
        gpio_out_value <= 1'b1;
        gpio_out_enable <= 1'b1;
        repeat (3) @(posedge core_clk);
        check({clock_output_pin_oe, clock_output_pin}, 2'b11, "pin as plain output");
        gpio_out_enable <= 1'b0;
        repeat (3) @(posedge core_clk);
        check(clock_output_pin_oe, 1'b0, "pin as plain input");
        ctl(8'h18);
        meas(4'h0);
        check(32'(n > 10), 32'h1, "synthesiser on pin");
        ctl(8'h1c);
        meas(4'h0);
        check(n, 32'h0, "synthesiser halted");
        check({synth_power_down, clock_output_pin}, 2'b10, "power down state");
        ctl(8'h28);
        check({clock_output_pin_oe, clock_output_pin}, 2'b10, "held low");
        ctl(8'h38);
        check({clock_output_pin_oe, clock_output_pin}, 2'b11, "held high");
        rd(CLOCK_OUT_STATUS_ADR, 32'h7, "status while held high");
        for (int k = 0; k < 4; k++) begin
            ctl(8'h48 + 8'(k * 16));
            meas(4'h0);
            check(n, 32'(64 >> k), "reference division");
        end
        ctl(8'h40);
        meas(4'h0);
        check({n[30:0], clock_output_pin_oe}, 32'h0, "pin disabled");
        for (int c = 12; c < 16; c++) begin
            ctl(8'(c * 16 + 8));
            check(clock_output_pin_oe, 1'b0, "reserved source");
        end
        for (int c = 0; c < 4; c++) begin
            ctl(8'h88 + 8'(c * 16));
            for (int j = 0; j < 4; j++) begin
                meas(4'h1 << j);
                check(n, (c == j) ? 32'h6 : 32'h0, "timer toggle");
            end
        end
        for (int f = 0; f < 4; f++) begin
            ctl(8'(f));
            check(loop_feedback_ratio, fb_exp[f], "feedback ratio");
            rd(SYNTH_LOOP_CONTROL_ADR, 32'(f), "control readback");
        end
        bus(1'b1, SYNTH_OUTPUT_DIVIDER_ADR, 8'hfe);
        repeat (3) @(posedge core_clk);
        check(loop_output_divide, 8'hfe, "top divider");
        rd(SYNTH_OUTPUT_DIVIDER_ADR, 32'hfe, "divider readback");
        bus(1'b1, SYNTH_OUTPUT_DIVIDER_ADR, 8'h08);
        repeat (3) @(posedge core_clk);
        check(loop_output_divide, 8'h08, "lowest divider");
        bus(1'b1, SYNTH_OUTPUT_DIVIDER_ADR, 8'h05);
        repeat (3) @(posedge core_clk);
        check(loop_output_divide, OUTPUT_DIVIDER_MIN, "reserved divider clamped");
        rd(SYNTH_OUTPUT_DIVIDER_ADR, 32'h05, "reserved divider readback");
        rd(CLOCK_OUT_STATUS_ADR, 32'hd, "status with reserved divider");
        // Second reset in mid-run must bring the registers back
        arst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        rd(SYNTH_OUTPUT_DIVIDER_ADR, 32'h8, "divider after second reset");
        rd(SYNTH_LOOP_CONTROL_ADR, 32'h0, "control after second reset");
        finish_test();
    end

    // Whole run is under two thousand cycles; this limit leaves ample margin
    initial begin
        repeat (20000) @(posedge core_clk);
        mismatches++;
        finish_test();
    end
endmodule
